// ### logic/eac_defs.svh
`ifndef EAC_DEFS_SVH
`define EAC_DEFS_SVH

// ----------------------------------------------------------------
// I/O space layout
// ----------------------------------------------------------------
`define EAC_IO_DATA_OFS 8'h20
`define EAC_IO_TOP 8'h3F
`define EAC_BIT_TOP 6'h1F
`define EAC_OFS_ADDR_HI 6'h22
`define EAC_OFS_ADDR_LO 6'h21
`define EAC_OFS_DATA 6'h20
`define EAC_OFS_CTRL 6'h1F
`define EAC_OFS_STAT 6'h1D

// ----------------------------------------------------------------
// Field positions and reset values
// ----------------------------------------------------------------
`define EAC_CTRL_RIE 3
`define EAC_CTRL_MWE 2
`define EAC_CTRL_WE 1
`define EAC_CTRL_RE 0
`define EAC_STAT_REFUSED 0
`define EAC_CTRL_USED_MASK 8'h0F
`define EAC_CTRL_RESET 8'h00
`define EAC_ADDR_BITS 10
`define EAC_ADDR_HI_BITS 2

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define EAC_READ_STALL 3'h4
`define EAC_WRITE_STALL 3'h2
`define EAC_MWE_WINDOW 3'h4
`define EAC_WRITE_RC_CYCLES 27072
`define EAC_WRITE_TIME_US 3400

`endif

// ### logic/eac_pkg.sv
`include "eac_defs.svh"
package eac_pkg;

  typedef logic [5:0] eac_ioaddr_t;

  typedef enum logic {
    EAC_WR_IDLE,
    EAC_WR_PROGRAM
  } eac_wr_state_e;

  typedef struct packed {
    logic hit;
    logic bitOk;
    eac_ioaddr_t idx;
  } eac_decode_s;

  // Maps an I/O-instruction or data-space address onto the I/O index
  function automatic eac_decode_s eac_decode(input logic [7:0] addr,
                                             input logic dataSpace);
    eac_decode_s d;
    logic [7:0] io;
    io = dataSpace ? addr - `EAC_IO_DATA_OFS : addr;
    d.hit = dataSpace ? (addr >= `EAC_IO_DATA_OFS
                         && addr <= `EAC_IO_TOP + `EAC_IO_DATA_OFS)
                      : (addr <= `EAC_IO_TOP);
    d.idx = io[5:0];
    d.bitOk = d.hit && !dataSpace && (io[5:0] <= `EAC_BIT_TOP);
    return d;
  endfunction : eac_decode

endpackage : eac_pkg

// ### logic/eac_if.sv
`timescale 1ns/1ps
interface eac_if;
  logic [7:0] ioAddr;
  logic dataSpace;
  logic [7:0] ioWdata;
  logic ioWr;
  logic ioRd;
  logic ioBitSet;
  logic ioBitClr;
  logic [2:0] bitSel;
  logic gie;
  logic [7:0] ioRdata;
  logic stall;
  logic readyIrq;
  logic writeBusy;

  modport dev (
    input ioAddr, dataSpace, ioWdata, ioWr, ioRd, ioBitSet, ioBitClr,
    input bitSel, gie,
    output ioRdata, stall, readyIrq, writeBusy
  );
  modport cpu (
    output ioAddr, dataSpace, ioWdata, ioWr, ioRd, ioBitSet, ioBitClr,
    output bitSel, gie,
    input ioRdata, stall, readyIrq, writeBusy
  );
endinterface : eac_if

// ### logic/eac_device.sv
`timescale 1ns/1ps
`include "eac_defs.svh"
// Contract
// - I/O index 0x00-0x3F, data space plus 0x20
// - Bit set/clear only below 0x20, one bit
// - Some flags clear by writing one
// - Software writes reserved bits as zero
// - Read strobe stalls CPU four cycles
// - Write start stalls CPU two cycles
// - Ten-bit address, upper six bits read zero
// - Address undefined at reset; software loads it
// - Data register feeds writes, receives reads
// - Control bits 7:4 read zero
// - Ready interrupt while enabled and strobe clear
// - Master enable self-clears after four cycles
// - Strobe starts write only under master enable
// - Software follows the ordered write sequence
// - No programming while flash self-write busy
// - Write strobe stays set until write done
// - Write lasts 27,072 oscillator cycles
// - Read strobe loads data register at once
// - Busy write blocks reads and address changes
// - Software keeps interrupts off during sequence
// - Reset does not abort a running write
module eac_device #(
  parameter int DEPTH = 1024,
  parameter int WRITE_CYCLES = `EAC_WRITE_RC_CYCLES
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic powerOnRst,
  input wire logic clkEn,
  input wire logic selfProgramBusy,
  output logic writeActive,
  eac_if.dev link
);

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  localparam int CW = $clog2(WRITE_CYCLES + 1);

  eac_pkg::eac_decode_s dec;
  eac_pkg::eac_wr_state_e wrState;
  logic [7:0] mem [DEPTH];
  logic [`EAC_ADDR_BITS-1:0] byteAddr, wrAddr;
  logic [7:0] byteData, wrData, touch, wval, next_rdata;
  logic [2:0] mweCnt, stallCnt;
  logic [CW-1:0] wrCnt;
  logic readyIrqEnable, masterWriteEnable, refused, wrBusy;
  logic anyWr, ctlWr, statWr, startWrite, refuseWrite, startRead;

  // ----------------------------------------------------------------
  // Access decode
  // ----------------------------------------------------------------
  // Index lookup for both I/O and data-space forms
  assign dec = eac_pkg::eac_decode(link.ioAddr, link.dataSpace);

  // Bit ops only reach low registers and touch one bit
  always_comb begin
    anyWr = 1'b0;
    touch = 8'h00;
    wval = link.ioWdata;
    if (link.ioWr && dec.hit) begin
      anyWr = 1'b1;
      touch = 8'hFF;
    end else if ((link.ioBitSet || link.ioBitClr) && dec.bitOk) begin
      anyWr = 1'b1;
      touch = 8'h01 << link.bitSel;
      wval = {8{link.ioBitSet}};
    end
  end

  assign ctlWr = anyWr && (dec.idx == `EAC_OFS_CTRL);
  assign statWr = anyWr && (dec.idx == `EAC_OFS_STAT);
  assign wrBusy = (wrState == eac_pkg::EAC_WR_PROGRAM);

  // A strobe set counts only while master enable already stands
  assign startWrite = ctlWr && touch[`EAC_CTRL_WE] && wval[`EAC_CTRL_WE]
    && masterWriteEnable && !wrBusy && !selfProgramBusy;
  assign refuseWrite = ctlWr && touch[`EAC_CTRL_WE]
    && wval[`EAC_CTRL_WE] && !wrBusy && !startWrite;
  assign startRead = ctlWr && touch[`EAC_CTRL_RE]
    && wval[`EAC_CTRL_RE] && !wrBusy;

  // ----------------------------------------------------------------
  // Address and data registers
  // ----------------------------------------------------------------
  // Address has no reset value; software must load it first
  always_ff @(posedge clk) begin
    if (clkEn && anyWr && !wrBusy) begin
      if (dec.idx == `EAC_OFS_ADDR_LO) begin
        for (int b = 0; b < 8; b++) begin
          if (touch[b]) begin
            byteAddr[b] <= wval[b];
          end
        end
      end else if (dec.idx == `EAC_OFS_ADDR_HI) begin
        for (int b = 0; b < `EAC_ADDR_HI_BITS; b++) begin
          if (touch[b]) begin
            byteAddr[8+b] <= wval[b];
          end
        end
      end
    end
  end

  // Data register: software byte, or the byte read out
  always_ff @(posedge clk) begin
    if (clkEn) begin
      if (startRead) begin
        byteData <= mem[byteAddr];
      end else if (anyWr && dec.idx == `EAC_OFS_DATA) begin
        byteData <= (byteData & ~touch) | (wval & touch);
      end
    end
  end

  // ----------------------------------------------------------------
  // Control and status bits
  // ----------------------------------------------------------------
  // Ready interrupt enable
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      readyIrqEnable <= 1'b0;
    end else if (clkEn && ctlWr && touch[`EAC_CTRL_RIE]) begin
      readyIrqEnable <= wval[`EAC_CTRL_RIE];
    end
  end

  // Master enable opens a window that closes by itself
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      masterWriteEnable <= 1'b0;
      mweCnt <= 3'h0;
    end else if (clkEn) begin
      if (ctlWr && touch[`EAC_CTRL_MWE] && wval[`EAC_CTRL_MWE]) begin
        masterWriteEnable <= 1'b1;
        mweCnt <= `EAC_MWE_WINDOW;
      end else if (mweCnt != 3'h0) begin
        mweCnt <= mweCnt - 3'h1;
        if (mweCnt == 3'h1) begin
          masterWriteEnable <= 1'b0;
        end
      end
    end
  end

  // Refused-strobe flag, cleared by writing one; a new refusal wins
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      refused <= 1'b0;
    end else if (clkEn) begin
      if (refuseWrite) begin
        refused <= 1'b1;
      end else if (statWr && touch[`EAC_STAT_REFUSED]
                   && wval[`EAC_STAT_REFUSED]) begin
        refused <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // CPU stall
  // ----------------------------------------------------------------
  // Holds the CPU for a fixed count after a read or write start
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      stallCnt <= 3'h0;
      link.stall <= 1'b0;
    end else if (clkEn) begin
      if (startRead) begin
        stallCnt <= `EAC_READ_STALL;
        link.stall <= 1'b1;
      end else if (startWrite) begin
        stallCnt <= `EAC_WRITE_STALL;
        link.stall <= 1'b1;
      end else if (stallCnt != 3'h0) begin
        stallCnt <= stallCnt - 3'h1;
        link.stall <= (stallCnt > 3'h1);
      end
    end
  end

  // ----------------------------------------------------------------
  // Self-timed write engine
  // ----------------------------------------------------------------
  // Only power-on reset stops it, so a system reset lets it finish
  always_ff @(posedge clk or posedge powerOnRst) begin
    if (powerOnRst) begin
      link.writeBusy <= 1'b0;
      writeActive <= 1'b0;
      wrState <= eac_pkg::EAC_WR_IDLE;
      wrCnt <= '0;
      wrAddr <= '0;
      wrData <= 8'h00;
    end else if (clkEn) begin
      link.writeBusy <= wrBusy;
      writeActive <= wrBusy;
      case (wrState)
        eac_pkg::EAC_WR_IDLE: begin
          if (startWrite && !sys_rst) begin
            wrState <= eac_pkg::EAC_WR_PROGRAM;
            wrCnt <= CW'(WRITE_CYCLES - 1);
            wrAddr <= byteAddr;
            wrData <= byteData;
          end
        end
        eac_pkg::EAC_WR_PROGRAM: begin
          if (wrCnt == '0) begin
            wrState <= eac_pkg::EAC_WR_IDLE;
          end else begin
            wrCnt <= wrCnt - CW'(1);
          end
        end
        default: begin
          wrState <= eac_pkg::EAC_WR_IDLE;
        end
      endcase
    end
  end

  // Cell array takes the byte as the write time ends
  always_ff @(posedge clk) begin
    if (clkEn && wrBusy && wrCnt == '0) begin
      mem[wrAddr] <= wrData;
    end
  end

  // ----------------------------------------------------------------
  // Read-back and status outputs
  // ----------------------------------------------------------------
  // Register read-back; unused and reserved bits read zero
  always_comb begin
    next_rdata = 8'h00;
    if (link.ioRd && dec.hit) begin
      case (dec.idx)
        `EAC_OFS_ADDR_HI: next_rdata = {6'h00, byteAddr[9:8]};
        `EAC_OFS_ADDR_LO: next_rdata = byteAddr[7:0];
        `EAC_OFS_DATA: next_rdata = byteData;
        `EAC_OFS_CTRL: next_rdata = {4'h0, readyIrqEnable,
                                     masterWriteEnable, wrBusy,
                                     1'b0};
        `EAC_OFS_STAT: next_rdata = {7'h00, refused};
        default: next_rdata = 8'h00;
      endcase
    end
  end

  // Read data stands only in the cycle after the read
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      link.ioRdata <= 8'h00;
    end else if (clkEn) begin
      link.ioRdata <= next_rdata;
    end
  end

  // Ready interrupt holds while no write is running
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      link.readyIrq <= 1'b0;
    end else if (clkEn) begin
      link.readyIrq <= readyIrqEnable && link.gie && !wrBusy;
    end
  end

endmodule : eac_device

// ### logic/eac_host.sv
`timescale 1ns/1ps
`include "eac_defs.svh"
module eac_host (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic clkEn,
  input wire logic [7:0] cmdAddr,
  input wire logic cmdDataSpace,
  input wire logic [7:0] cmdWdata,
  input wire logic cmdWr,
  input wire logic cmdRd,
  input wire logic cmdBitSet,
  input wire logic cmdBitClr,
  input wire logic [2:0] cmdBitSel,
  input wire logic globalIrqEn,
  output logic [7:0] cmdRdata,
  output logic cmdBusy,
  output logic irqPending,
  eac_if.cpu link
);

  // ----------------------------------------------------------------
  // Command forwarding
  // ----------------------------------------------------------------
  eac_pkg::eac_decode_s dec;
  logic ctlTarget;
  logic setsMwe;
  logic setsWe;
  logic mweBlocked;
  logic [2:0] holdCnt;

  assign dec = eac_pkg::eac_decode(cmdAddr, cmdDataSpace);
  assign ctlTarget = dec.hit && dec.idx == `EAC_OFS_CTRL;
  assign setsMwe = ctlTarget && ((cmdWr && cmdWdata[`EAC_CTRL_MWE])
    || (cmdBitSet && cmdBitSel == 3'(`EAC_CTRL_MWE)));
  assign setsWe = ctlTarget && ((cmdWr && cmdWdata[`EAC_CTRL_WE])
    || (cmdBitSet && cmdBitSel == 3'(`EAC_CTRL_WE)));

  // Arming is held back while a write is still running
  assign mweBlocked = setsMwe && link.writeBusy;

  // Strobes pass only while the device does not stall
  assign link.ioAddr = cmdAddr;
  assign link.dataSpace = cmdDataSpace;
  assign link.bitSel = cmdBitSel;
  assign link.ioWr = cmdWr && !link.stall && !mweBlocked;
  assign link.ioRd = cmdRd && !link.stall;
  assign link.ioBitSet = cmdBitSet && !link.stall && !mweBlocked;
  assign link.ioBitClr = cmdBitClr && !link.stall;

  // Reserved control bits always go out as zero
  assign link.ioWdata = ctlTarget ? (cmdWdata & `EAC_CTRL_USED_MASK)
                                  : cmdWdata;

  // Device flops reach the user side unchanged
  assign cmdRdata = link.ioRdata;
  assign cmdBusy = link.stall;
  assign irqPending = link.readyIrq;

  // ----------------------------------------------------------------
  // Interrupt hold across the write sequence
  // ----------------------------------------------------------------

  // Masks the global enable from arming until strobe or timeout
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      holdCnt <= 3'h0;
      link.gie <= 1'b0;
    end else if (clkEn) begin
      if (setsMwe && !link.stall && !mweBlocked) begin
        holdCnt <= `EAC_MWE_WINDOW;
        link.gie <= 1'b0;
      end else if (setsWe || holdCnt == 3'h0) begin
        holdCnt <= 3'h0;
        link.gie <= globalIrqEn;
      end else begin
        holdCnt <= holdCnt - 3'h1;
        link.gie <= 1'b0;
      end
    end
  end

endmodule : eac_host

// ### verif/eac_link_sva.sv
`timescale 1ns/1ps
// ------------------------------------------------------------
// Link protocol checks
// ------------------------------------------------------------
module eac_link_chk #(
  parameter int WRITE_CYCLES = 27072
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic [7:0] ioAddr,
  input wire logic dataSpace,
  input wire logic ioRd,
  input wire logic ioBitSet,
  input wire logic [2:0] bitSel,
  input wire logic gie,
  input wire logic [7:0] ioRdata,
  input wire logic stall,
  input wire logic readyIrq,
  input wire logic writeBusy
);
  logic [15:0] busyCnt = 16'h0000;
  logic ctlSet;

  // Bit set on the control register through I/O space
  assign ctlSet = ioBitSet && !dataSpace && ioAddr == 8'h1F;

  // Length of the current write, kept across a system reset
  always_ff @(posedge clk) begin
    busyCnt <= writeBusy ? busyCnt + 16'h0001 : 16'h0000;
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  read_stall_a: assert property (ctlSet && bitSel == 3'h0 && !stall
    && !writeBusy |=> stall [*4] ##1 !stall) else $error("read stall");
  write_stall_a: assert property ($rose(writeBusy) |-> $past(stall)
    && stall ##1 !stall) else $error("write stall");
  stall_cause_a: assert property ($rose(stall) |-> $past(ctlSet))
    else $error("stall without strobe");
  busy_read_a: assert property (writeBusy && !stall && ctlSet
    && bitSel == 3'h0 |=> !stall) else $error("read during write");
  irq_busy_a: assert property (writeBusy |-> !readyIrq)
    else $error("ready irq while busy");
  irq_gate_a: assert property (!gie |=> !readyIrq)
    else $error("ready irq without gie");
  ctl_reserved_a: assert property (ioRd && !dataSpace && ioAddr == 8'h1F
    |=> ioRdata[7:4] == 4'h0) else $error("control high bits");
  addr_high_a: assert property (ioRd && !dataSpace && ioAddr == 8'h22
    |=> ioRdata[7:2] == 6'h00) else $error("address high bits");
  write_len_a: assert property ($fell(writeBusy)
    |-> busyCnt == WRITE_CYCLES) else $error("write length");
endmodule : eac_link_chk

// ### verif/tb.sv
`timescale 1ns/1ps
`define CHK(n, g, e) begin comparisons++; if ((g) !== (e)) begin \
  error_cnt++; $display("[FAIL] %s exp %h got %h", n, e, g); end end
module tb;
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic powerOnRst = 1'b1;
  logic spBusy = 1'b0;
  logic [7:0] cmdAddr = 8'h00;
  logic cmdDataSpace = 1'b0;
  logic [7:0] cmdWdata = 8'h00;
  logic cmdWr = 1'b0;
  logic cmdRd = 1'b0;
  logic cmdBitSet = 1'b0;
  logic cmdBitClr = 1'b0;
  logic [2:0] cmdBitSel = 3'h0;
  logic globalIrqEn = 1'b0;
  logic [7:0] cmdRdata;
  logic cmdBusy;
  logic irqPending;
  logic writeActive;
  int error_cnt = 0;
  int comparisons = 0;
  int n;

  // 40 MHz clock
  always #12.5 clk = ~clk;

  // ------------------------------------------------------------
  // Both ends and the checker
  // ------------------------------------------------------------
  eac_if lnk ();
  eac_device #(.DEPTH(1024), .WRITE_CYCLES(20)) eac_device_inst (
    .clk(clk), .sys_rst(sys_rst), .powerOnRst(powerOnRst), .clkEn(1'b1),
    .selfProgramBusy(spBusy), .writeActive(writeActive), .link(lnk.dev));
  eac_host eac_host_inst (
    .clk(clk), .sys_rst(sys_rst), .clkEn(1'b1), .cmdAddr(cmdAddr),
    .cmdDataSpace(cmdDataSpace), .cmdWdata(cmdWdata), .cmdWr(cmdWr),
    .cmdRd(cmdRd), .cmdBitSet(cmdBitSet), .cmdBitClr(cmdBitClr),
    .cmdBitSel(cmdBitSel), .globalIrqEn(globalIrqEn), .cmdRdata(cmdRdata),
    .cmdBusy(cmdBusy), .irqPending(irqPending), .link(lnk.cpu));
  eac_link_chk #(.WRITE_CYCLES(20)) eac_link_chk_inst (
    .clk(clk), .sys_rst(sys_rst), .ioAddr(lnk.ioAddr),
    .dataSpace(lnk.dataSpace), .ioRd(lnk.ioRd), .ioBitSet(lnk.ioBitSet),
    .bitSel(lnk.bitSel), .gie(lnk.gie), .ioRdata(lnk.ioRdata),
    .stall(lnk.stall), .readyIrq(lnk.readyIrq), .writeBusy(lnk.writeBusy));

  // ------------------------------------------------------------
  // Access tasks: kind 0 idle, 1 write, 2 read, 3 bit set, 4 bit clear
  // ------------------------------------------------------------
  task automatic go(input logic [2:0] k, input logic [7:0] a,
                    input logic ds, input logic [7:0] d,
                    input logic [2:0] b);
    int w;
    w = 0;
    while (k != 3'h0 && cmdBusy === 1'b1 && w < 200) begin
      @(posedge clk);
      #1;
      w++;
    end
    if (w == 200) `CHK("stall ends", cmdBusy, 1'b0)
    cmdWr <= (k == 3'h1);
    cmdRd <= (k == 3'h2);
    cmdBitSet <= (k == 3'h3);
    cmdBitClr <= (k == 3'h4);
    cmdAddr <= a;
    cmdDataSpace <= ds;
    cmdWdata <= d;
    cmdBitSel <= b;
    @(posedge clk);
    #1;
  endtask : go

  task automatic idle(input int c);
    repeat (c) go(3'h0, 8'h00, 1'b0, 8'h00, 3'h0);
  endtask : idle

  task automatic wr(input logic [7:0] a, input logic ds, input logic [7:0] d);
    go(3'h1, a, ds, d, 3'h0);
    idle(1);
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic ds, input logic [7:0] e,
                    input string nm);
    go(3'h2, a, ds, 8'h00, 3'h0);
    `CHK(nm, cmdRdata, e)
    idle(1);
  endtask : rd

  task automatic bo(input logic [2:0] k, input logic [7:0] a,
                    input logic [2:0] b);
    go(k, a, 1'b0, 8'h00, b);
    idle(1);
  endtask : bo

  // Verdict and end of run
  task automatic conclude();
    $display("comparisons %0d mismatches %0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : conclude

  // Watchdog against a hung handshake
  initial begin
    repeat (5000) @(posedge clk);
    error_cnt++;
    conclude();
  end

  // ------------------------------------------------------------
  // Test sequence
  // ------------------------------------------------------------
  initial begin
    repeat (2) @(posedge clk);
    #1;
    sys_rst <= 1'b0;
    powerOnRst <= 1'b0;
    globalIrqEn <= 1'b1;
    // Register map and reset values
    rd(8'h1F, 1'b0, 8'h00, "ctl reset");
    wr(8'h22, 1'b0, 8'hFF);
    rd(8'h22, 1'b0, 8'h03, "addr hi");
    wr(8'h21, 1'b0, 8'h5A);
    rd(8'h41, 1'b1, 8'h5A, "addr lo data space");
    wr(8'h40, 1'b1, 8'hA5);
    rd(8'h20, 1'b0, 8'hA5, "data reg");
    $display("map test done");
    // Single-bit access and enable timeout
    wr(8'h1F, 1'b0, 8'h08);
    bo(3'h3, 8'h1F, 3'h2);
    rd(8'h1F, 1'b0, 8'h0C, "bit set one bit");
    idle(2);
    rd(8'h1F, 1'b0, 8'h08, "enable self clear");
    bo(3'h4, 8'h20, 3'h0);
    rd(8'h20, 1'b0, 8'hA5, "bit op above 1F");
    `CHK("ready irq", irqPending, 1'b1)
    $display("bit test done");
    // Late strobe and flash interlock are refused
    wr(8'h1F, 1'b0, 8'h0C);
    idle(6);
    bo(3'h3, 8'h1F, 3'h1);
    `CHK("late strobe", lnk.writeBusy, 1'b0)
    rd(8'h1D, 1'b0, 8'h01, "refused flag");
    wr(8'h1D, 1'b0, 8'h00);
    rd(8'h1D, 1'b0, 8'h01, "flag zero write");
    wr(8'h1D, 1'b0, 8'h01);
    rd(8'h1D, 1'b0, 8'h00, "flag one clears");
    spBusy <= 1'b1;
    wr(8'h1F, 1'b0, 8'h0C);
    bo(3'h3, 8'h1F, 3'h1);
    `CHK("flash interlock", lnk.writeBusy, 1'b0)
    spBusy <= 1'b0;
    $display("refusal test done");
    // Full write with blocked accesses and a reset in mid-write
    wr(8'h1F, 1'b0, 8'h0C);
    bo(3'h3, 8'h1F, 3'h1);
    rd(8'h1F, 1'b0, 8'h0A, "strobe while busy");
    `CHK("busy flag", writeActive, 1'b1)
    `CHK("irq while busy", irqPending, 1'b0)
    wr(8'h21, 1'b0, 8'h00);
    rd(8'h21, 1'b0, 8'h5A, "addr locked");
    bo(3'h3, 8'h1F, 3'h0);
    `CHK("read refused", cmdBusy, 1'b0)
    sys_rst <= 1'b1;
    idle(1);
    sys_rst <= 1'b0;
    idle(1);
    `CHK("write survives reset", lnk.writeBusy, 1'b1)
    n = 0;
    while (lnk.writeBusy === 1'b1 && n < 100) begin
      idle(1);
      n++;
    end
    `CHK("write ends", lnk.writeBusy, 1'b0)
    rd(8'h1F, 1'b0, 8'h00, "ctl after write");
    wr(8'h20, 1'b0, 8'h00);
    bo(3'h3, 8'h1F, 3'h0);
    `CHK("read stall", cmdBusy, 1'b1)
    rd(8'h20, 1'b0, 8'hA5, "read back");
    $display("write test done");
    conclude();
  end
endmodule : tb
